/* rtl/bbs_regs.svh */
// bbs_regs.svh: register offsets, field positions and reset values of the execution unit
// Assumes byte addresses on an AXI4-Lite bus, one aligned 32-bit word per register
`ifndef BBS_REGS_SVH
`define BBS_REGS_SVH

// Register byte offsets
`define BBS_CMD_OFS    8'h00
`define BBS_OPND_OFS   8'h04
`define BBS_RES_OFS    8'h08
`define BBS_CTL_OFS    8'h0c
`define BBS_PC_OFS     8'h10
`define BBS_SRC_OFS    8'h14
`define BBS_DST_OFS    8'h18
`define BBS_CNT_OFS    8'h1c
`define BBS_STAT_OFS   8'h20
`define BBS_TGT_OFS    8'h24
`define BBS_RET_OFS    8'h28

// Command word fields
`define BBS_CMD_SEL    5
`define BBS_CMD_MEM    6
`define BBS_CMD_BREG   7

// Condition flag positions
`define BBS_FLG_C      0
`define BBS_FLG_V      1
`define BBS_FLG_Z      2
`define BBS_FLG_N      3
`define BBS_FLG_I      7

// Reset values and steps
`define BBS_CC_RST     8'h80
`define BBS_XC_RST     8'h00
`define BBS_PC_STEP    24'h000002
`define BBS_PTR_STEP   32'h00000001
`define BBS_TRAP_BASE  24'h000020

// AXI responses
`define BBS_RESP_OK    2'h0
`define BBS_RESP_SLV   2'h2
`define BBS_RESP_DEC   2'h3

`endif

/* rtl/bbs_pkg.sv */
// bbs_pkg.sv: operation, condition and state types of the execution unit
// Assumes nothing beyond the regs header for numbers
package bbs_pkg;

   typedef enum logic [4:0] {
      op_no_operation       = 5'h00,
      op_bit_xor_carry      = 5'h01,
      op_bit_inv_xor_carry  = 5'h02,
      op_bit_load_carry     = 5'h03,
      op_bit_inv_load_carry = 5'h04,
      op_bit_store_carry    = 5'h05,
      op_bit_inv_store_carry= 5'h06,
      op_branch_cond        = 5'h07,
      op_jump_uncond        = 5'h08,
      op_rel_sub_call       = 5'h09,
      op_abs_sub_call       = 5'h0a,
      op_sub_return         = 5'h0b,
      op_trap_instr         = 5'h0c,
      op_exception_return   = 5'h0d,
      op_sleep              = 5'h0e,
      op_load_control_reg   = 5'h0f,
      op_store_control_reg  = 5'h10,
      op_and_control_imm    = 5'h11,
      op_or_control_imm     = 5'h12,
      op_xor_control_imm    = 5'h13,
      op_block_move_byte    = 5'h14,
      op_block_move_word    = 5'h15
   } bbs_op_e;

   typedef enum logic [3:0] {
      cond_always = 4'h0, cond_never  = 4'h1, cond_higher = 4'h2, cond_lower_same = 4'h3,
      cond_cc     = 4'h4, cond_cs     = 4'h5, cond_ne     = 4'h6, cond_eq         = 4'h7,
      cond_vc     = 4'h8, cond_vs     = 4'h9, cond_pl     = 4'ha, cond_mi         = 4'hb,
      cond_ge     = 4'hc, cond_lt     = 4'hd, cond_gt     = 4'he, cond_le         = 4'hf
   } bbs_cond_e;

   typedef enum logic [1:0] {
      st_idle = 2'h0,
      st_exec = 2'h1,
      st_rd   = 2'h2,
      st_wr   = 2'h3
   } bbs_state_e;

endpackage : bbs_pkg

/* rtl/bbs_cond.sv */
// bbs_cond.sv: branch condition evaluation from the flag byte
// Assumes the flag layout of the regs header; purely combinational
`timescale 1ns/1ns
`include "bbs_regs.svh"

module bbs_cond (
   input  wire logic [3:0] cond,
   input  wire logic [7:0] flags,
   output logic            taken
);
   import bbs_pkg::*;

   logic c, v, z, n, base;

   // Pairs share one test; the low code bit selects the opposite sense
   always_comb begin
      c = flags[`BBS_FLG_C];
      v = flags[`BBS_FLG_V];
      z = flags[`BBS_FLG_Z];
      n = flags[`BBS_FLG_N];
      case (cond[3:1])
         3'h0:    base = 1'b1;
         3'h1:    base = ~(c | z);
         3'h2:    base = ~c;
         3'h3:    base = ~z;
         3'h4:    base = ~v;
         3'h5:    base = ~n;
         3'h6:    base = ~(n ^ v);
         3'h7:    base = ~(z | (n ^ v));
         default: base = 1'b0;
      endcase
      taken = base ^ cond[0];
   end

endmodule : bbs_cond

/* rtl/bbs_exec.sv */
// bbs_exec.sv: execution unit for carry-bit ops, branches, system control and block move
// Assumes an AXI4-Lite master for commands and a byte memory with valid/ready handshake
//
// The AXI4-Lite slave port and the register offsets were decided locally.

`timescale 1ns/1ns
`include "bbs_regs.svh"

module bbs_exec (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             mem_valid,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ready,
   output logic             power_down
);
   import bbs_pkg::*;

   logic        awready_q, aw_hold_q, wready_q, w_hold_q, bvalid_q, arready_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   bbs_state_e  st_q;
   logic [31:0] cmd_q, src_q, dst_q;
   logic [23:0] pc_q, tgt_q, ret_q, sv_pc_q;
   logic [15:0] opnd_q, res_q, cnt_q;
   logic [7:0]  ccode_q, xctl_q, sv_cc_q, data_q;
   logic        sleep_q, taken_q, mem_valid_q, mem_we_q;
   logic [31:0] mem_addr_q;
   logic [7:0]  mem_wdata_q;

   logic        wr_fire, wr_hit, wr_ok, rd_hit;
   logic [31:0] wr_word;
   bbs_op_e     op;
   logic        inv_op, sel_x, mem_form, cond_ok, carry, new_bit, cnt_zero;
   logic [2:0]  bit_no;
   logic [7:0]  imm, ctl_cur, st_byte, ctl_new;
   logic [15:0] cnt_cur, cnt_dec;
   logic [23:0] pc_next;

   // Register view used by both reads and byte-masked writes
   function automatic logic [31:0] reg_view(input logic [7:0] a);
      case (a)
         `BBS_CMD_OFS:  reg_view = cmd_q;
         `BBS_OPND_OFS: reg_view = {16'h0000, opnd_q};
         `BBS_RES_OFS:  reg_view = {16'h0000, res_q};
         `BBS_CTL_OFS:  reg_view = {16'h0000, xctl_q, ccode_q};
         `BBS_PC_OFS:   reg_view = {8'h00, pc_q};
         `BBS_SRC_OFS:  reg_view = src_q;
         `BBS_DST_OFS:  reg_view = dst_q;
         `BBS_CNT_OFS:  reg_view = {16'h0000, cnt_q};
         `BBS_STAT_OFS: reg_view = {29'h00000000, taken_q, sleep_q, st_q != st_idle};
         `BBS_TGT_OFS:  reg_view = {8'h00, tgt_q};
         `BBS_RET_OFS:  reg_view = {8'h00, ret_q};
         default:       reg_view = 32'h00000000;
      endcase
   endfunction : reg_view

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'h0) && (a <= `BBS_RET_OFS);
   endfunction : is_mapped

   // Write side merges strobed lanes into the current value
   always_comb begin
      wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
      wr_hit  = is_mapped(awaddr_q);
      wr_ok   = wr_fire && wr_hit && (st_q == st_idle);
      rd_hit  = is_mapped(araddr);
      wr_word = reg_view(awaddr_q);
      for (int i = 0; i < 4; i++) begin
         if (wstrb_q[i]) wr_word[8*i +: 8] = wdata_q[8*i +: 8];
      end
   end

   // Write address and data are caught independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         aw_hold_q <= 1'b0;
         awaddr_q  <= 8'h00;
         wready_q  <= 1'b1;
         w_hold_q  <= 1'b0;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
      end else begin
         if (awvalid && awready_q) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= awaddr;
            awready_q <= 1'b0;
         end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
            awready_q <= 1'b1;
         end
         if (wvalid && wready_q) begin
            w_hold_q <= 1'b1;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
            wready_q <= 1'b0;
         end else if (wr_fire) begin
            w_hold_q <= 1'b0;
            wready_q <= 1'b1;
         end
      end
   end

   // Write response; a busy unit refuses writes so a running move is never corrupted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `BBS_RESP_OK;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= !wr_hit ? `BBS_RESP_DEC :
                     (st_q != st_idle) ? `BBS_RESP_SLV : `BBS_RESP_OK;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read channel answers one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `BBS_RESP_OK;
      end else if (arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= reg_view(araddr);
         rresp_q   <= rd_hit ? `BBS_RESP_OK : `BBS_RESP_DEC;
      end else if (rvalid_q && rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   bbs_cond u_cond (
      .cond  (cmd_q[15:12]),
      .flags (ccode_q),
      .taken (cond_ok)
   );

   // Command decode and operand selection
   always_comb begin
      op       = bbs_op_e'(cmd_q[4:0]);
      sel_x    = cmd_q[`BBS_CMD_SEL];
      mem_form = cmd_q[`BBS_CMD_MEM];
      imm      = cmd_q[23:16];
      inv_op   = (op == op_bit_inv_xor_carry) || (op == op_bit_inv_load_carry) ||
                 (op == op_bit_inv_store_carry);
      bit_no   = (cmd_q[`BBS_CMD_BREG] && !inv_op) ? opnd_q[10:8] : cmd_q[10:8];
      carry    = ccode_q[`BBS_FLG_C];
      new_bit  = (op == op_bit_inv_store_carry) ? ~carry : carry;
      st_byte  = opnd_q[7:0];
      st_byte[bit_no] = new_bit;
      ctl_cur  = sel_x ? xctl_q : ccode_q;
      case (op)
         op_and_control_imm: ctl_new = ctl_cur & imm;
         op_or_control_imm:  ctl_new = ctl_cur | imm;
         op_xor_control_imm: ctl_new = ctl_cur ^ imm;
         default:            ctl_new = mem_form ? opnd_q[15:8] : opnd_q[7:0];
      endcase
      cnt_cur  = (op == op_block_move_word) ? cnt_q : {8'h00, cnt_q[7:0]};
      cnt_zero = (cnt_cur == 16'h0000);
      cnt_dec  = cnt_cur - 16'h0001;
      pc_next  = pc_q + `BBS_PC_STEP;
   end

   // Architectural state: software loads it only while idle, commands update it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q    <= st_idle;
         cmd_q   <= 32'h00000000;
         opnd_q  <= 16'h0000;
         res_q   <= 16'h0000;
         pc_q    <= 24'h000000;
         tgt_q   <= 24'h000000;
         ret_q   <= 24'h000000;
         sv_pc_q <= 24'h000000;
         sv_cc_q <= `BBS_CC_RST;
         ccode_q <= `BBS_CC_RST;
         xctl_q  <= `BBS_XC_RST;
         src_q   <= 32'h00000000;
         dst_q   <= 32'h00000000;
         cnt_q   <= 16'h0000;
         data_q  <= 8'h00;
         sleep_q <= 1'b0;
         taken_q <= 1'b0;
      end else begin
         case (st_q)
            st_idle: begin
               if (wr_ok) begin
                  case (awaddr_q)
                     `BBS_CMD_OFS: begin
                        cmd_q   <= wr_word;
                        sleep_q <= 1'b0;   // A new command is the wake-up event
                        st_q    <= st_exec;
                     end
                     `BBS_OPND_OFS: opnd_q <= wr_word[15:0];
                     `BBS_PC_OFS:   pc_q   <= wr_word[23:0];
                     `BBS_SRC_OFS:  src_q  <= wr_word;
                     `BBS_DST_OFS:  dst_q  <= wr_word;
                     `BBS_CNT_OFS:  cnt_q  <= wr_word[15:0];
                     `BBS_TGT_OFS:  tgt_q  <= wr_word[23:0];
                     default: ;
                  endcase
               end
            end
            st_exec: begin
               st_q <= st_idle;
               pc_q <= pc_next;
               case (op)
                  op_bit_xor_carry:       ccode_q[`BBS_FLG_C] <= carry ^ opnd_q[bit_no];
                  op_bit_inv_xor_carry:   ccode_q[`BBS_FLG_C] <= carry ^ ~opnd_q[bit_no];
                  op_bit_load_carry:      ccode_q[`BBS_FLG_C] <= opnd_q[bit_no];
                  op_bit_inv_load_carry:  ccode_q[`BBS_FLG_C] <= ~opnd_q[bit_no];
                  op_bit_store_carry,
                  op_bit_inv_store_carry: res_q <= {8'h00, st_byte};
                  op_branch_cond: begin
                     taken_q <= cond_ok;
                     if (cond_ok) pc_q <= tgt_q;
                  end
                  op_jump_uncond: pc_q <= tgt_q;
                  op_rel_sub_call,
                  op_abs_sub_call: begin
                     ret_q <= pc_next;
                     pc_q  <= tgt_q;
                  end
                  op_sub_return: pc_q <= ret_q;
                  op_trap_instr: begin
                     sv_pc_q <= pc_next;
                     sv_cc_q <= ccode_q;
                     ccode_q[`BBS_FLG_I] <= 1'b1;
                     pc_q    <= `BBS_TRAP_BASE + {20'h00000, imm[1:0], 2'h0};
                  end
                  op_exception_return: begin
                     pc_q    <= sv_pc_q;
                     ccode_q <= sv_cc_q;
                  end
                  op_sleep: sleep_q <= 1'b1;
                  op_load_control_reg,
                  op_and_control_imm,
                  op_or_control_imm,
                  op_xor_control_imm: begin
                     if (sel_x) xctl_q <= ctl_new;
                     else       ccode_q <= ctl_new;
                  end
                  op_store_control_reg:
                     res_q <= mem_form ? {ctl_cur, 8'h00} : {8'h00, ctl_cur};
                  op_block_move_byte,
                  op_block_move_word: begin
                     if (!cnt_zero) begin
                        pc_q <= pc_q;
                        st_q <= st_rd;
                     end
                  end
                  default: ;
               endcase
            end
            st_rd: begin
               if (mem_ready) begin
                  data_q <= mem_rdata;
                  src_q  <= src_q + `BBS_PTR_STEP;
                  st_q   <= st_wr;
               end
            end
            st_wr: begin
               if (mem_ready) begin
                  dst_q <= dst_q + `BBS_PTR_STEP;
                  if (op == op_block_move_word) cnt_q <= cnt_dec;
                  else                          cnt_q[7:0] <= cnt_dec[7:0];
                  if (cnt_dec == 16'h0000) begin
                     pc_q <= pc_next;
                     st_q <= st_idle;
                  end else begin
                     st_q <= st_rd;
                  end
               end
            end
            default: st_q <= st_idle;
         endcase
      end
   end

   // Memory port; each request is held until the memory answers ready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_valid_q <= 1'b0;
         mem_we_q    <= 1'b0;
         mem_addr_q  <= 32'h00000000;
         mem_wdata_q <= 8'h00;
      end else begin
         if (st_q == st_exec && (op == op_block_move_byte || op == op_block_move_word) &&
             !cnt_zero) begin
            mem_valid_q <= 1'b1;
            mem_we_q    <= 1'b0;
            mem_addr_q  <= src_q;
         end else if (st_q == st_rd && mem_ready) begin
            mem_we_q    <= 1'b1;
            mem_addr_q  <= dst_q;
            mem_wdata_q <= mem_rdata;
         end else if (st_q == st_wr && mem_ready) begin
            mem_we_q    <= 1'b0;
            mem_addr_q  <= src_q;
            mem_valid_q <= (cnt_dec != 16'h0000);
         end
      end
   end

   assign awready    = awready_q;
   assign wready     = wready_q;
   assign bvalid     = bvalid_q;
   assign bresp      = bresp_q;
   assign arready    = arready_q;
   assign rvalid     = rvalid_q;
   assign rdata      = rdata_q;
   assign rresp      = rresp_q;
   assign mem_valid  = mem_valid_q;
   assign mem_we     = mem_we_q;
   assign mem_addr   = mem_addr_q;
   assign mem_wdata  = mem_wdata_q;
   assign power_down = sleep_q;

   // Checks on the execution behaviour
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_exec(bbs_op_e o);
      st_q == st_exec && op == o;
   endsequence

   sequence s_last_write;
      st_q == st_wr && mem_ready && cnt_dec == 16'h0000;
   endsequence

   bit_xor_a: assert property (s_exec(op_bit_xor_carry) |=>
      ccode_q[`BBS_FLG_C] == ($past(carry) ^ $past(opnd_q[bit_no])))
      else $error("carry xor result wrong");
   inv_xor_a: assert property (s_exec(op_bit_inv_xor_carry) |=>
      ccode_q[`BBS_FLG_C] != ($past(carry) ^ $past(opnd_q[bit_no])))
      else $error("inverted carry xor result wrong");
   bit_load_a: assert property (s_exec(op_bit_load_carry) |=>
      ccode_q[`BBS_FLG_C] == $past(opnd_q[bit_no]))
      else $error("bit load into carry wrong");
   inv_bitno_a: assert property (s_exec(op_bit_inv_load_carry) |=>
      ccode_q[`BBS_FLG_C] == ~$past(opnd_q[cmd_q[10:8]]))
      else $error("inverted form bit number not from immediate");
   bit_store_a: assert property (s_exec(op_bit_inv_store_carry) |=>
      res_q[$past(bit_no)] == ~$past(carry) && res_q[15:8] == 8'h00)
      else $error("inverted carry store wrong");
   branch_pc_a: assert property (s_exec(op_branch_cond) |=>
      pc_q == ($past(cond_ok) ? $past(tgt_q) : $past(pc_next)))
      else $error("branch target or fall-through wrong");
   nop_pc_a: assert property (s_exec(op_no_operation) |=>
      pc_q == $past(pc_q) + `BBS_PC_STEP && $stable(ccode_q) && $stable(xctl_q))
      else $error("no-operation changed more than the counter");
   sleep_enter_a: assert property (s_exec(op_sleep) |=> power_down)
      else $error("sleep did not enter power-down");
   ctl_store_a: assert property (s_exec(op_store_control_reg) ##0 mem_form
      |=> res_q == {$past(ctl_cur), 8'h00})
      else $error("control store to memory not in upper byte");
   zero_cnt_a: assert property ((st_q == st_exec && cnt_zero &&
      (op == op_block_move_byte || op == op_block_move_word)) |=> st_q == st_idle && !mem_valid)
      else $error("zero count moved data");
   ptr_step_a: assert property (st_q == st_wr && mem_ready |=>
      dst_q == $past(dst_q) + `BBS_PTR_STEP)
      else $error("destination pointer step wrong");
   move_end_a: assert property (s_last_write |=>
      st_q == st_idle && pc_q == $past(pc_next) && !mem_valid)
      else $error("move did not finish on last byte");

endmodule : bbs_exec

/* tb/bbs_mem_model.sv */
// bbs_mem_model.sv: byte memory on the unit's request port
// Assumes requests are held until mem_ready; answers alternate fast and slow
`timescale 1ns/1ns
module bbs_mem_model (
   input  wire logic        aclk,
   input  wire logic        mem_valid,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic [7:0]       mem_rdata = 8'h00,
   output logic             mem_ready = 1'b0
);
   logic [7:0] mem [0:1023];
   logic [1:0] wait_q = 2'h0;
   logic       slow_q = 1'b0;
   // Data toggles when unanswered, so a stale byte never looks valid
   always @(posedge aclk) begin
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_valid && !mem_ready) begin
         wait_q <= wait_q - 2'h1;
         if (wait_q == 2'h0) begin
            mem_ready <= 1'b1;
            wait_q <= {slow_q, 1'b0};
            slow_q <= ~slow_q;
            if (mem_we)
               mem[mem_addr[9:0]] <= mem_wdata;
            else
               mem_rdata <= mem[mem_addr[9:0]];
         end
      end
   end
endmodule : bbs_mem_model

/* tb/bbs_exec_tb.sv */
// bbs_exec_tb.sv: self-checking bench of the execution unit
// Assumes the memory model on the request port; AXI4-Lite driven here
`timescale 1ns/1ns
module bbs_exec_tb;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0, mem_wdata, mem_rdata;
   logic [31:0] wdata = 32'h0, rdata, mem_addr;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, mem_valid, mem_we, mem_ready, power_down;
   logic [1:0] bresp, rresp, wr_resp;
   int error_cnt = 0, n_tests = 0;
   always #5 aclk = ~aclk;
   bbs_exec dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .mem_valid, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
      .mem_ready, .power_down);
   bbs_mem_model mem_u (.aclk, .mem_valid, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
      .mem_ready);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic results();
      $display("Checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   // Both write channels offered at once, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      wr_resp = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(d & m, e);
   endtask : rdc
   // Command issue, then poll busy; the watchdog bounds a hang
   task automatic run(input logic [31:0] c);
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(8'h00, c);
      do
         axi_rd(8'h20, d, r);
      while (d[0] !== 1'b0);
   endtask : run
   task automatic set_cc(input logic [7:0] v, input logic s);
      axi_wr(8'h04, {24'h0, v});
      run({8'h0, v, 10'h0, s, 5'h0f});
   endtask : set_cc
   task automatic t_bits();
      logic [2:0] b;
      logic [4:0] op;
      logic c, x, ec;
      logic [7:0] er;
      for (int i = 0; i < 12; i++) begin
         op = 5'(1 + i / 2);
         c = i[0];
         b = 3'(i * 3);
         x = 1'(8'ha5 >> b);
         er = 8'ha5;
         er[b] = (op == 5'h6) ? ~c : c;
         ec = (op == 1) ? c ^ x : (op == 2) ? ~(c ^ x) : (op == 3) ? x : (op == 4) ? ~x : c;
         set_cc({7'h0, c}, 1'b0);
         axi_wr(8'h04, 32'ha5);
         run({16'h0, 5'h0, b, 3'h0, op});
         rdc(8'h0c, 32'h1, {31'h0, ec});
         if (op > 5'h4)
            rdc(8'h08, 32'hff, {24'h0, er});
      end
   endtask : t_bits
   task automatic t_branch();
      logic n, z, v, c, t;
      for (int f = 0; f < 16; f++) begin
         {n, z, v, c} = 4'(f);
         set_cc({4'h0, n, z, v, c}, 1'b0);
         for (int k = 0; k < 16; k++) begin
            t = (k < 2) ? 1'b1 : (k < 4) ? ~(c | z) : (k < 6) ? ~c : (k < 8) ? ~z
              : (k < 10) ? ~v : (k < 12) ? ~n : (k < 14) ? ~(n ^ v) : ~(z | (n ^ v));
            run({16'h0, 4'(k), 7'h0, 5'h07});
            rdc(8'h20, 32'h4, {29'h0, t ^ k[0], 2'h0});
         end
      end
   endtask : t_branch
   // And, or, xor chained so one wrong operator shows in the end value
   task automatic t_ctl();
      for (int s = 0; s < 2; s++) begin
         set_cc(8'h0f, s[0]);
         run({8'h0, 8'h35, 10'h0, s[0], 5'h11});
         run({8'h0, 8'h50, 10'h0, s[0], 5'h12});
         run({8'h0, 8'hff, 10'h0, s[0], 5'h13});
         rdc(8'h0c, s ? 32'hff00 : 32'hff, s ? 32'haa00 : 32'haa);
      end
   endtask : t_ctl
   task automatic t_sys();
      logic [31:0] p;
      logic [1:0] r;
      run(32'h0e);
      chk({31'h0, power_down}, 32'h1);
      run(32'h00);
      chk({31'h0, power_down}, 32'h0);
      axi_rd(8'h10, p, r);
      run(32'h00);
      rdc(8'h10, 32'hffffff, (p + 32'h2) & 32'hffffff);
      axi_rd(8'h40, p, r);
      chk({30'h0, r}, 32'h3);
      axi_wr(8'h40, 32'h0);
      chk({30'h0, wr_resp}, 32'h3);
   endtask : t_sys
   task automatic t_move();
      logic [31:0] p;
      logic [1:0] r;
      for (int i = 0; i < 4; i++)
         mem_u.mem[10'h100 + 10'(i)] = 8'h3c + 8'(i);
      mem_u.mem[10'h203] = 8'h77;
      axi_wr(8'h14, 32'h100);
      axi_wr(8'h18, 32'h200);
      axi_wr(8'h1c, 32'h3);
      axi_rd(8'h10, p, r);
      // The command starts the move; a count write during the move is refused
      axi_wr(8'h00, 32'h15);
      axi_wr(8'h1c, 32'h5);
      chk({30'h0, wr_resp}, 32'h2);
      run(32'h00);
      for (int i = 0; i < 4; i++)
         chk({24'h0, mem_u.mem[10'h200 + 10'(i)]}, (i < 3) ? 32'h3c + 32'(i) : 32'h77);
      rdc(8'h14, 32'hffffffff, 32'h103);
      rdc(8'h18, 32'hffffffff, 32'h203);
      rdc(8'h1c, 32'hffff, 32'h0);
      rdc(8'h10, 32'hffffff, (p + 32'h2) & 32'hffffff);
      axi_wr(8'h1c, 32'h100);
      run(32'h14);
      rdc(8'h1c, 32'hffff, 32'h100);
      rdc(8'h14, 32'hffffffff, 32'h103);
      axi_wr(8'h1c, 32'h101);
      run(32'h14);
      rdc(8'h1c, 32'hffff, 32'h100);
      rdc(8'h14, 32'hffffffff, 32'h104);
   endtask : t_move
   // Jump, call, return, trap, exception return, control moves, register bit number
   task automatic t_flow();
      axi_wr(8'h24, 32'h400);
      run(32'h08);
      rdc(8'h10, 32'hffffff, 32'h400);
      axi_wr(8'h24, 32'h800);
      run(32'h0a);
      rdc(8'h10, 32'hffffff, 32'h800);
      rdc(8'h28, 32'hffffff, 32'h402);
      run(32'h0b);
      rdc(8'h10, 32'hffffff, 32'h402);
      set_cc(8'h05, 1'b0);
      run(32'h0003000c);
      rdc(8'h10, 32'hffffff, 32'h2c);
      rdc(8'h0c, 32'hff, 32'h85);
      run(32'h11);
      run(32'h0d);
      rdc(8'h10, 32'hffffff, 32'h406);
      rdc(8'h0c, 32'hff, 32'h05);
      run(32'h50);
      rdc(8'h08, 32'hffff, 32'h0500);
      run(32'h30);
      rdc(8'h08, 32'hffff, 32'h00aa);
      axi_wr(8'h04, 32'h3340);
      run(32'h4f);
      rdc(8'h0c, 32'hff, 32'h33);
      axi_wr(8'h04, 32'h0640);
      run(32'h83);
      rdc(8'h0c, 32'h1, 32'h1);
      run(32'h84);
      rdc(8'h0c, 32'h1, 32'h1);
   endtask : t_flow
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      results();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_bits();
      $display("Done bit ops");
      t_branch();
      $display("Done branches");
      t_ctl();
      $display("Done control logic");
      t_sys();
      $display("Done system");
      t_flow();
      $display("Done flow control");
      t_move();
      $display("Done block move");
      results();
   end
endmodule : bbs_exec_tb
